// *** rtl/stb_defs.svh ***
// Purpose: Register offsets, field positions and reset values for the sensor tail bank.
// Assumes: Two-wire slave with an 8-bit register pointer and 16-bit words.
// Notes:   Definitions only.
// Behaviour
// - Offset word is read/write, clears at reset.
// - Single scratch word read/write at 08h.
// - Identification word at 0Fh ignores writes.
// - Identification bits 15:12 give silicon revision.
// - Identification bits 11:0 give fixed part code.
// - Slave only; never starts a bus transfer.
// - Strap pin selects one of four addresses.
// - Limit flag asserts when thresholds 02h/03h passed.
// - Offset added to linearized two's-complement temperature.
// - Overflowing sum saturates to maximum or minimum.
`ifndef STB_DEFS_SVH
`define STB_DEFS_SVH

`define STB_PTR_RESULT   8'h00
`define STB_PTR_HIGH     8'h02
`define STB_PTR_LOW      8'h03
`define STB_PTR_OFFSET   8'h07
`define STB_PTR_SCRATCH  8'h08
`define STB_PTR_ID       8'h0F

`define STB_ID_REV_MSB   15
`define STB_ID_REV_LSB   12
`define STB_ID_PART_MSB  11
`define STB_ID_PART_LSB  0

`define STB_OFFSET_RST   16'h0000
`define STB_SCRATCH_RST  16'h0000
`define STB_HIGH_RST     16'h6000
`define STB_LOW_RST      16'h8000
`define STB_RESULT_RST   16'h0000
`define STB_WORD_MAX     16'h7FFF
`define STB_WORD_MIN     16'h8000

`define STB_ADDR_BASE    7'h48
`define STB_BITS_BYTE    4'h8
`define STB_BITS_LAST    4'h7

`endif

// *** rtl/stb_pkg.sv ***
// Purpose: Types shared by the sensor tail bank.
// Assumes: Nothing beyond the defines header.
// Notes:   States are one-hot.
package stb_pkg;

  typedef logic [15:0] stb_word_t;

  typedef enum logic [6:0]
  {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_RX       = 7'h08,
    ST_RX_ACK   = 7'h10,
    ST_TX       = 7'h20,
    ST_TX_ACK   = 7'h40
  } stb_state_t;

  typedef struct packed
  {
    logic scl;
    logic sda;
  } stb_lines_t;

  typedef struct packed
  {
    logic seen_low;
    logic seen_high;
    logic diff_sda;
    logic diff_scl;
  } stb_strap_t;

endpackage

// *** rtl/stb_sat_add.sv ***
// Purpose: Saturating two's-complement adder for the temperature correction.
// Assumes: Both operands use the same fixed-point format.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "stb_defs.svh"

module stb_sat_add
(
  // Operands
  input  wire stb_pkg::stb_word_t  raw_in,
  input  wire stb_pkg::stb_word_t  offset_in,
  // Result
  output var  stb_pkg::stb_word_t  sum_out
);
  import stb_pkg::*;

  logic [16:0] wide;

  always_comb
  begin
    wide = {raw_in[15], raw_in} + {offset_in[15], offset_in};
    if (wide[16] != wide[15])
    begin
      sum_out = wide[16] ? `STB_WORD_MIN : `STB_WORD_MAX;
    end
    else
    begin
      sum_out = wide[15:0];
    end
  end

endmodule

`default_nettype wire

// *** rtl/stb_tail_bank.sv ***
// Purpose: Two-wire slave register bank with offset correction and limit flag.
// Assumes: Bus lines and strap are synchronous to CLK_IN and much slower than it.
// Notes:   Write is pointer, MSB, LSB; read returns MSB then LSB of the pointed word.
`timescale 1ns/1ps
`default_nettype none
`include "stb_defs.svh"

module stb_tail_bank
#(
  parameter logic [3:0]  REVISION  = 4'h0,
  parameter logic [11:0] PART_ID   = 12'hA5C,
  parameter logic [6:0]  ADDR_BASE = `STB_ADDR_BASE
)
(
  // Clock, reset, enable
  input  wire logic                CLK_IN,
  input  wire logic                SRST_IN,
  input  wire logic                CE_IN,
  // Two-wire bus
  input  wire logic                SCL_IN,
  input  wire logic                SDA_IN,
  output var  logic                SDA_OUT,
  output var  logic                SDA_OE_OUT,
  // Address strap
  input  wire logic                BUS_ADDRESS_STRAP_IN,
  // Conversion result
  input  wire stb_pkg::stb_word_t  TEMP_RAW_IN,
  input  wire logic                TEMP_VALID_IN,
  output var  stb_pkg::stb_word_t  TEMP_RESULT_OUT,
  // Limit flag
  output var  logic                ALERT_OUT,
  output var  logic                ALERT_OE_OUT
);
  import stb_pkg::*;

  stb_state_t  state,    next_state;
  stb_lines_t  line_q,   next_line_q;
  stb_strap_t  strap,    next_strap;
  logic [3:0]  bit_cnt,  next_bit_cnt;
  logic [7:0]  shift,    next_shift;
  logic [1:0]  byte_idx, next_byte_idx;
  logic        rw,       next_rw;
  logic        tx_lsb,   next_tx_lsb;
  logic [7:0]  ptr,      next_ptr;
  logic [7:0]  msb_hold, next_msb_hold;
  stb_word_t   tx_word,  next_tx_word;
  logic        sda_oe,   next_sda_oe;
  stb_word_t   offset,   next_offset;
  stb_word_t   scratch,  next_scratch;
  stb_word_t   high_lim, next_high_lim;
  stb_word_t   low_lim,  next_low_lim;
  stb_word_t   result,   next_result;
  logic        alert,    next_alert;
  stb_word_t   corrected;
  stb_word_t   ptr_word;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic [6:0]  my_addr;
  logic [7:0]  tx_byte;

  function automatic stb_word_t read_word(input logic [7:0] p);
    stb_word_t w;
    w = 16'h0000;
    case (p)
      `STB_PTR_RESULT:  w = result;
      `STB_PTR_HIGH:    w = high_lim;
      `STB_PTR_LOW:     w = low_lim;
      `STB_PTR_OFFSET:  w = offset;
      `STB_PTR_SCRATCH: w = scratch;
      `STB_PTR_ID:
      begin
        w[`STB_ID_REV_MSB:`STB_ID_REV_LSB]   = REVISION;
        w[`STB_ID_PART_MSB:`STB_ID_PART_LSB] = PART_ID;
      end
      default:          w = 16'h0000;
    endcase
    return w;
  endfunction

  // Strap tied to ground or supply never toggles; tied to a bus line it follows that line.
  function automatic logic [6:0] strap_addr(input stb_strap_t s);
    logic [6:0] idx;
    idx = 7'h00;
    if (!s.seen_high)
    begin
      idx = 7'h00;
    end
    else if (!s.seen_low)
    begin
      idx = 7'h01;
    end
    else if (!s.diff_sda)
    begin
      idx = 7'h02;
    end
    else
    begin
      idx = 7'h03;
    end
    return ADDR_BASE + idx;
  endfunction

  stb_sat_add u_sat_add
  (
    .raw_in    (TEMP_RAW_IN),
    .offset_in (offset),
    .sum_out   (corrected)
  );

  always_comb
  begin
    scl_rise  = SCL_IN & ~line_q.scl;
    scl_fall  = ~SCL_IN & line_q.scl;
    bus_start = SCL_IN & line_q.scl & line_q.sda & ~SDA_IN;
    bus_stop  = SCL_IN & line_q.scl & ~line_q.sda & SDA_IN;
    my_addr   = strap_addr(strap);
    tx_byte   = tx_lsb ? tx_word[15:8] : tx_word[7:0];
    ptr_word  = read_word(ptr);

    next_state    = state;
    next_line_q   = line_q;
    next_strap    = strap;
    next_bit_cnt  = bit_cnt;
    next_shift    = shift;
    next_byte_idx = byte_idx;
    next_rw       = rw;
    next_tx_lsb   = tx_lsb;
    next_ptr      = ptr;
    next_msb_hold = msb_hold;
    next_tx_word  = tx_word;
    next_sda_oe   = sda_oe;
    next_offset   = offset;
    next_scratch  = scratch;
    next_high_lim = high_lim;
    next_low_lim  = low_lim;
    next_result   = result;

    next_line_q.scl = SCL_IN;
    next_line_q.sda = SDA_IN;

    if (!BUS_ADDRESS_STRAP_IN)
    begin
      next_strap.seen_low = 1'b1;
    end
    else
    begin
      next_strap.seen_high = 1'b1;
    end
    if (BUS_ADDRESS_STRAP_IN != SDA_IN)
    begin
      next_strap.diff_sda = 1'b1;
    end
    if (BUS_ADDRESS_STRAP_IN != SCL_IN)
    begin
      next_strap.diff_scl = 1'b1;
    end

    if (TEMP_VALID_IN)
    begin
      next_result = corrected;
    end
    next_alert = ($signed(result) > $signed(high_lim)) ||
                 ($signed(result) < $signed(low_lim));

    // The bank only follows the host's clock and its start and stop conditions.
    if (bus_stop)
    begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
    end
    else if (bus_start)
    begin
      next_state   = ST_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe  = 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          next_sda_oe = 1'b0;
        end
        ST_ADDR:
        begin
          if (scl_rise)
          begin
            next_shift   = {shift[6:0], SDA_IN};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == `STB_BITS_BYTE)
          begin
            next_bit_cnt = 4'h0;
            if (shift[7:1] == my_addr)
            begin
              next_state   = ST_ADDR_ACK;
              next_sda_oe  = 1'b1;
              next_rw      = shift[0];
              next_tx_word = read_word(ptr);
            end
            else
            begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            next_bit_cnt = 4'h0;
            if (rw)
            begin
              next_state  = ST_TX;
              next_tx_lsb = 1'b0;
              next_shift  = tx_word[15:8];
              next_sda_oe = ~tx_word[15];
            end
            else
            begin
              next_state    = ST_RX;
              next_byte_idx = 2'h0;
              next_sda_oe   = 1'b0;
            end
          end
        end
        ST_RX:
        begin
          if (scl_rise)
          begin
            next_shift   = {shift[6:0], SDA_IN};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == `STB_BITS_BYTE)
          begin
            next_state   = ST_RX_ACK;
            next_sda_oe  = 1'b1;
            next_bit_cnt = 4'h0;
            if (byte_idx != 2'h3)
            begin
              next_byte_idx = byte_idx + 2'h1;
            end
            case (byte_idx)
              2'h0:    next_ptr = shift;
              2'h1:    next_msb_hold = shift;
              2'h2:
              begin
                case (ptr)
                  `STB_PTR_OFFSET:  next_offset   = {msb_hold, shift};
                  `STB_PTR_SCRATCH: next_scratch  = {msb_hold, shift};
                  `STB_PTR_HIGH:    next_high_lim = {msb_hold, shift};
                  `STB_PTR_LOW:     next_low_lim  = {msb_hold, shift};
                  default:          next_offset   = offset;
                endcase
              end
              default: next_ptr = ptr;
            endcase
          end
        end
        ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            next_state  = ST_RX;
            next_sda_oe = 1'b0;
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == `STB_BITS_LAST)
            begin
              next_state   = ST_TX_ACK;
              next_sda_oe  = 1'b0;
              next_bit_cnt = 4'h0;
            end
            else
            begin
              next_bit_cnt = bit_cnt + 4'h1;
              next_shift   = {shift[6:0], 1'b0};
              next_sda_oe  = ~shift[6];
            end
          end
        end
        ST_TX_ACK:
        begin
          if (scl_rise && SDA_IN)
          begin
            next_state = ST_IDLE;
          end
          else if (scl_fall)
          begin
            next_state  = ST_TX;
            next_tx_lsb = ~tx_lsb;
            next_shift  = tx_byte;
            next_sda_oe = ~tx_byte[7];
            if (tx_lsb)
            begin
              next_tx_word = ptr_word;
              next_shift   = ptr_word[15:8];
              next_sda_oe  = ~ptr_word[15];
            end
          end
        end
        default:
        begin
          next_state  = ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      state    <= ST_IDLE;
      line_q   <= 2'b11;
      strap    <= 4'h0;
      bit_cnt  <= 4'h0;
      shift    <= 8'h00;
      byte_idx <= 2'h0;
      rw       <= 1'b0;
      tx_lsb   <= 1'b0;
      ptr      <= 8'h00;
      msb_hold <= 8'h00;
      tx_word  <= 16'h0000;
      sda_oe   <= 1'b0;
      offset   <= `STB_OFFSET_RST;
      scratch  <= `STB_SCRATCH_RST;
      high_lim <= `STB_HIGH_RST;
      low_lim  <= `STB_LOW_RST;
      result   <= `STB_RESULT_RST;
      alert    <= 1'b0;
    end
    else if (CE_IN)
    begin
      state    <= next_state;
      line_q   <= next_line_q;
      strap    <= next_strap;
      bit_cnt  <= next_bit_cnt;
      shift    <= next_shift;
      byte_idx <= next_byte_idx;
      rw       <= next_rw;
      tx_lsb   <= next_tx_lsb;
      ptr      <= next_ptr;
      msb_hold <= next_msb_hold;
      tx_word  <= next_tx_word;
      sda_oe   <= next_sda_oe;
      offset   <= next_offset;
      scratch  <= next_scratch;
      high_lim <= next_high_lim;
      low_lim  <= next_low_lim;
      result   <= next_result;
      alert    <= next_alert;
    end
  end

  // Both pins only ever pull low.
  assign SDA_OUT         = 1'b0;
  assign SDA_OE_OUT      = sda_oe;
  assign ALERT_OUT       = 1'b0;
  assign ALERT_OE_OUT    = alert;
  assign TEMP_RESULT_OUT = result;

endmodule

`default_nettype wire

// *** bench/stb_tail_bank_assertions.sv ***
// Purpose: Port-level checks for the sensor tail bank.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module stb_tail_bank_assertions
(
  // Observed ports
  input wire logic               CLK_IN,
  input wire logic               SRST_IN,
  input wire logic               SCL_IN,
  input wire logic               SDA_OUT,
  input wire logic               SDA_OE_OUT,
  input wire logic               TEMP_VALID_IN,
  input wire stb_pkg::stb_word_t TEMP_RESULT_OUT,
  input wire logic               ALERT_OUT,
  input wire logic               ALERT_OE_OUT
);
  import stb_pkg::*;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SRST_IN);
  sequence scl_held;
    SCL_IN ##1 SCL_IN;
  endsequence
  sequence drive_begins;
    $rose(SDA_OE_OUT);
  endsequence
  a_sda_low_only: assert property (SDA_OUT == 1'b0)
    else $error("data pin driven high");
  a_alert_low_only: assert property (ALERT_OUT == 1'b0)
    else $error("limit pin driven high");
  a_data_scl_low: assert property ($changed(SDA_OE_OUT) |-> !SCL_IN && !$past(SCL_IN))
    else $error("data changed outside clock low");
  a_quiet_scl_high: assert property (scl_held |-> $stable(SDA_OE_OUT))
    else $error("data moved while clock high");
  a_drive_bounded: assert property (drive_begins |-> ##[1:400] !SDA_OE_OUT)
    else $error("data held low too long");
  a_reset_quiet: assert property ($past(SRST_IN) |-> !SDA_OE_OUT && !ALERT_OE_OUT
    && TEMP_RESULT_OUT == 16'h0000)
    else $error("outputs not cleared by reset");
  a_result_cause: assert property ($changed(TEMP_RESULT_OUT) |-> $past(TEMP_VALID_IN))
    else $error("result changed without sample");
  a_alert_cause: assert property ($changed(ALERT_OE_OUT) |-> $past(TEMP_VALID_IN, 2) || !SCL_IN)
    else $error("limit flag changed without cause");
endmodule
`default_nettype wire

// *** bench/stb_host_model.sv ***
// Purpose: Two-wire host model that drives the bank's bus.
// Assumes: Data line has a pull-up; the host alone drives the clock.
// Notes:   Each data-bit clock phase lasts four or five system clocks.
`timescale 1ns/1ps
`default_nettype none
module stb_host_model
(
  // Clock and bus
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_oe_out
);
  initial
  begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_oe_out = !b;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    r = sda_in;
    scl_out = 1'b0;
    tick(1);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                      output logic nk);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ak, nk);
  endtask
  task automatic start();
    sda_oe_out = 1'b0;
    tick(2);
    scl_out = 1'b1;
    tick(4);
    sda_oe_out = 1'b1;
    tick(4);
    scl_out = 1'b0;
    tick(1);
  endtask
  task automatic stop();
    sda_oe_out = 1'b1;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    sda_oe_out = 1'b0;
    tick(4);
  endtask
  task automatic write_word(input logic [6:0] a, input logic [7:0] p, input logic [15:0] v,
                            output logic ok);
    logic [7:0] b [4];
    logic [7:0] rx;
    logic       nk;
    b = '{{a, 1'b0}, p, v[15:8], v[7:0]};
    ok = 1'b1;
    start();
    for (int i = 0; i < 4; i++)
    begin
      xfer(b[i], 1'b1, rx, nk);
      ok &= !nk;
    end
    stop();
  endtask
  task automatic read_word(input logic [6:0] a, input logic [7:0] p, output logic [15:0] v,
                           output logic ok);
    logic [7:0] rx;
    logic       nk;
    start();
    xfer({a, 1'b0}, 1'b1, rx, nk);
    ok = !nk;
    xfer(p, 1'b1, rx, nk);
    ok &= !nk;
    stop();
    start();
    xfer({a, 1'b1}, 1'b1, rx, nk);
    ok &= !nk;
    xfer(8'hFF, 1'b0, v[15:8], nk);
    xfer(8'hFF, 1'b1, v[7:0], nk);
    stop();
  endtask
endmodule
`default_nettype wire

// *** bench/stb_tail_bank_tb.sv ***
// Purpose: Self-checking bench for the sensor tail bank.
// Assumes: Host model drives the bus; the data line has a pull-up.
// Notes:   Seeded random words with fixed corner cases among them.
`timescale 1ns/1ps
`default_nettype none
`include "stb_defs.svh"
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("unexpected at %0t: got %h, want %h", $time, (got), (exp)); \
    end \
  end
module stb_tail_bank_tb;
  import stb_pkg::*;
  // Arbitrary identification values.
  localparam logic [3:0]  REV = 4'h3;
  localparam logic [11:0] PID = 12'h5A1;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       valid = 1'b0;
  logic       ce = 1'b1;
  stb_word_t  raw = 16'h0000;
  stb_word_t  result, hi, lo, off, d, r;
  logic       scl, host_oe, sda_oe, alert_oe, strap, sda, ok;
  logic [1:0] mode = 2'h0;
  integer     seed = 21;
  int         mismatches = 0;
  int         n_tests = 0;
  stb_word_t  corner [6] = '{16'h00FF, 16'h0100, 16'hFEFE, 16'hFEFF, 16'h7FFF, 16'h8000};
  assign sda = !(host_oe | sda_oe);
  assign strap = (mode == 2'h0) ? 1'b0 : (mode == 2'h1) ? 1'b1 : (mode == 2'h2) ? sda : scl;
  always #5 clk = !clk;
  stb_tail_bank #(.REVISION(REV), .PART_ID(PID)) dut_u (.CLK_IN(clk), .SRST_IN(srst),
    .CE_IN(ce), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE_OUT(sda_oe),
    .BUS_ADDRESS_STRAP_IN(strap), .TEMP_RAW_IN(raw), .TEMP_VALID_IN(valid),
    .TEMP_RESULT_OUT(result), .ALERT_OUT(), .ALERT_OE_OUT(alert_oe));
  stb_host_model host_u (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(host_oe));
  function automatic stb_word_t sat(stb_word_t a, stb_word_t b);
    int s;
    s = $signed(a) + $signed(b);
    if (s > 32767)
      return `STB_WORD_MAX;
    if (s < -32768)
      return `STB_WORD_MIN;
    return 16'(s);
  endfunction
  task automatic rst();
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
  endtask
  task automatic wr(input logic [7:0] p, input stb_word_t v);
    host_u.write_word(`STB_ADDR_BASE, p, v, ok);
    `CHK(ok, 1'b1)
  endtask
  task automatic rd(input logic [7:0] p, output stb_word_t v);
    host_u.read_word(`STB_ADDR_BASE, p, v, ok);
    `CHK(ok, 1'b1)
  endtask
  task automatic temp(input stb_word_t v);
    stb_word_t e;
    e = sat(v, off);
    @(posedge clk);
    #1 raw = v;
    valid = 1'b1;
    @(posedge clk);
    #1 valid = 1'b0;
    @(posedge clk);
    #1;
    `CHK(result, e)
    `CHK(alert_oe, ($signed(e) > $signed(hi)) || ($signed(e) < $signed(lo)))
  endtask
  task automatic summarize();
    $display("mismatches %0d, checks %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #400_000;
    mismatches++;
    summarize();
  end
  initial
  begin
    for (int m = 3; m >= 0; m--)
    begin
      mode = 2'(m);
      rst();
      host_u.read_word(`STB_ADDR_BASE + 7'(m), `STB_PTR_ID, r, ok);
      `CHK(ok, 1'b1)
      `CHK(r, {REV, PID})
      host_u.write_word(`STB_ADDR_BASE + 7'((m + 1) % 4), `STB_PTR_OFFSET, 16'hFFFF, ok);
      `CHK(ok, 1'b0)
      host_u.read_word(`STB_ADDR_BASE + 7'(m), `STB_PTR_OFFSET, r, ok);
      `CHK(r, 16'h0000)
    end
    wr(`STB_PTR_ID, 16'($random(seed)));
    rd(`STB_PTR_ID, r);
    `CHK(r, {REV, PID})
    hi = `STB_HIGH_RST;
    lo = `STB_LOW_RST;
    off = 16'h0000;
    d = 16'($random(seed));
    wr(`STB_PTR_SCRATCH, d);
    for (int i = 0; i < 3; i++)
    begin
      rd(`STB_PTR_SCRATCH, r);
      `CHK(r, d)
      off = 16'($random(seed));
      wr(`STB_PTR_OFFSET, off);
      rd(`STB_PTR_OFFSET, r);
      `CHK(r, off)
      hi = 16'($random(seed));
      lo = 16'($random(seed));
      wr(`STB_PTR_HIGH, hi);
      wr(`STB_PTR_LOW, lo);
      temp(16'($random(seed)));
      temp(16'($random(seed)));
    end
    rd(`STB_PTR_SCRATCH, r);
    `CHK(r, d)
    hi = 16'h0100;
    lo = 16'hFF00;
    wr(`STB_PTR_HIGH, hi);
    wr(`STB_PTR_LOW, lo);
    rd(`STB_PTR_HIGH, r);
    `CHK(r, hi)
    for (int k = 0; k < 2; k++)
    begin
      off = k ? 16'hFFFF : 16'h0001;
      wr(`STB_PTR_OFFSET, off);
      foreach (corner[j])
        temp(corner[j]);
    end
    // A sample offered while the clock enable is low must not be taken.
    @(posedge clk);
    #1 ce = 1'b0;
    raw = 16'h0123;
    valid = 1'b1;
    @(posedge clk);
    #1 valid = 1'b0;
    ce = 1'b1;
    @(posedge clk);
    #1;
    `CHK(result, sat(corner[5], off))
    summarize();
  end
endmodule
bind stb_tail_bank stb_tail_bank_assertions chk_u (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN),
  .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .TEMP_VALID_IN(TEMP_VALID_IN),
  .TEMP_RESULT_OUT(TEMP_RESULT_OUT), .ALERT_OUT(ALERT_OUT), .ALERT_OE_OUT(ALERT_OE_OUT));
`default_nettype wire
